// [hw/pbc_consts.vh]
// Constants for the fallback clock control block.
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH
`define PBC_ADDR_W           9
`define PBC_DATA_W           16
`define PBC_OFS_MOD_SETUP    9'h1C6
`define PBC_OFS_FB_STATUS    9'h1C7
`define PBC_BIT_MOD_EN       0
`define PBC_BIT_SEL_12M      1
`define PBC_BIT_RET_EXT      0
`define PBC_BIT_DRV_OFF_EN   1
`define PBC_BIT_ON_BACKUP    8
`define PBC_BIT_CLK_LOST     9
`define PBC_BIT_LOCKED       10
`define PBC_BIT_FREQ_BAD     11
`define PBC_RST_MOD_SETUP    16'h0001
`define PBC_RST_FB_STATUS    16'h0000
`define PBC_CLK_MHZ          40
`define PBC_LOCK_TIME_US     25
`define PBC_FILT_TIME_US     10
`define PBC_LOCK_CYC         (`PBC_LOCK_TIME_US * `PBC_CLK_MHZ)
`define PBC_FILT_CYC         (`PBC_FILT_TIME_US * `PBC_CLK_MHZ)
`define PBC_WIN_BK_CYC       8
`define PBC_LIM24_LO         8'h7F
`define PBC_LIM24_HI         8'hA3
`define PBC_LIM12_LO         8'h3F
`define PBC_LIM12_HI         8'h52
`define PBC_MUL_HI           24
`define PBC_MUL_LO           12
`define PBC_MOD_RATE_KHZ     25
`define PBC_MOD_PCT_X100     208
`endif

// [hw/pbc_lock_filter.v]
// Digital lock filter: output rises after input held high for a span.
`timescale 1ns/1ps
module pbc_lock_filter #(
  parameter CNT_W = 12,
  parameter SPAN  = 400
) (
  input  wire clk_in,
  input  wire ce_in,
  input  wire raw_in,
  output wire good_out
);
  reg [CNT_W-1:0] cnt_q;
  reg             good_q;
  // Counter restarts whenever the raw level drops.
  always @(posedge clk_in)
  begin
    if (ce_in)
    begin
      if (!raw_in)
      begin
        cnt_q  <= {CNT_W{1'b0}};
        good_q <= 1'b0;
      end
      else if (cnt_q >= SPAN[CNT_W-1:0] - 1'b1)
        good_q <= 1'b1;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end
  assign good_out = good_q;
endmodule // pbc_lock_filter

// [hw/pbc_freq_window.v]
// Counts logic cycles over a window of backup clock edges.
`timescale 1ns/1ps
`include "pbc_consts.vh"
module pbc_freq_window #(
  parameter WIN = 8
) (
  input  wire       clk_in,
  input  wire       ce_in,
  input  wire       rst_n_in,
  input  wire       bk_tick_in,
  input  wire       sel_12m_in,
  output wire       bad_out,
  output wire       done_out
);
  reg [8:0] cnt_q;
  reg [3:0] tick_q;
  reg       bad_q;
  reg       done_q;
  wire [8:0] lo = sel_12m_in ? {1'b0, `PBC_LIM12_LO} : {1'b0, `PBC_LIM24_LO};
  wire [8:0] hi = sel_12m_in ? {1'b0, `PBC_LIM12_HI} : {1'b0, `PBC_LIM24_HI};
  // Window state starts clean with the supply so that no unknown leaks out.
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q  <= 9'h000;
      tick_q <= 4'h0;
      bad_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else if (ce_in)
    begin
      done_q <= 1'b0;
      if (bk_tick_in && tick_q == WIN[3:0] - 4'h1)
      begin
        bad_q  <= (cnt_q < lo) || (cnt_q > hi);
        done_q <= 1'b1;
        tick_q <= 4'h0;
        cnt_q  <= 9'h000;
      end
      else
      begin
        if (bk_tick_in)
          tick_q <= tick_q + 4'h1;
        if (cnt_q != 9'h1FF)
          cnt_q <= cnt_q + 9'h001;
      end
    end
  end
  assign bad_out  = bad_q;
  assign done_out = done_q;
endmodule // pbc_freq_window

// [hw/pbc_clock_ctrl.v]
// Fallback clock control: source select, lock supervision, registers.
`timescale 1ns/1ps
`include "pbc_consts.vh"
module pbc_clock_ctrl #(
  parameter LOCK_CYC = `PBC_LOCK_CYC,
  parameter FILT_CYC = `PBC_FILT_CYC
) (
  input  wire                   clk_in,
  input  wire                   ce_in,
  input  wire                   rst_n_in,
  input  wire                   supply_good_in,
  input  wire                   external_reset_pin_in,
  input  wire                   ref_good_in,
  input  wire                   bk_tick_in,
  input  wire                   pll_lock_raw_in,
  input  wire                   wr_en_in,
  input  wire [`PBC_ADDR_W-1:0] addr_in,
  input  wire [`PBC_DATA_W-1:0] wdata_in,
  output reg  [`PBC_DATA_W-1:0] rdata_out,
  output wire                   use_backup_out,
  output wire                   pll_run_out,
  output wire                   pll_div2_out,
  output wire [4:0]             pll_mult_out,
  output wire                   mod_en_out,
  output wire                   clk_lost_out,
  output wire                   irq_out,
  output wire                   drv_off_out
);
  localparam ST_EXT = 2'h0;
  localparam ST_BAK = 2'h1;
  localparam ST_SW  = 2'h2;
  localparam [4:0] MUL_HI = `PBC_MUL_HI;
  localparam [4:0] MUL_LO = `PBC_MUL_LO;

  reg [1:0]  st_q;
  reg [1:0]  st_d;
  reg        bak_target_q;
  reg        use_backup_q;
  reg        mod_en_q;
  reg        sel_12m_q;
  reg        drv_off_en_q;
  reg        ret_req_q;
  reg        relock_q;
  reg [15:0] lock_cnt_q;
  reg        locked_q;
  wire       lock_filt;
  wire       freq_bad;
  wire       win_done;
  wire       sel_mod;
  wire       sel_sta;

  assign sel_mod = wr_en_in && addr_in == `PBC_OFS_MOD_SETUP;
  assign sel_sta = wr_en_in && addr_in == `PBC_OFS_FB_STATUS;

  pbc_lock_filter #(
    .CNT_W (16),
    .SPAN  (FILT_CYC)
  ) u_filt (
    .clk_in   (clk_in),
    .ce_in    (ce_in),
    .raw_in   (pll_lock_raw_in && !relock_q),
    .good_out (lock_filt)
  );

  pbc_freq_window #(
    .WIN (`PBC_WIN_BK_CYC)
  ) u_win (
    .clk_in     (clk_in),
    .ce_in      (ce_in),
    .rst_n_in   (supply_good_in),
    .bk_tick_in (bk_tick_in),
    .sel_12m_in (sel_12m_q),
    .bad_out    (freq_bad),
    .done_out   (win_done)
  );

  // Registers reset by the register reset only, never the PLL state.
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mod_en_q     <= 1'b1;
      sel_12m_q    <= 1'b0;
      drv_off_en_q <= 1'b0;
      ret_req_q    <= 1'b0;
    end
    else if (ce_in)
    begin
      if (sel_mod)
      begin
        mod_en_q  <= wdata_in[`PBC_BIT_MOD_EN];
        sel_12m_q <= wdata_in[`PBC_BIT_SEL_12M];
      end
      if (sel_sta)
        drv_off_en_q <= wdata_in[`PBC_BIT_DRV_OFF_EN];
      if (sel_sta && wdata_in[`PBC_BIT_RET_EXT])
        ret_req_q <= 1'b1;
      else if (st_q == ST_EXT || !use_backup_q)
        ret_req_q <= 1'b0;
    end
  end

  // Source state machine, independent of the external reset pin.
  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_EXT:
        if (!ref_good_in)
          st_d = ST_SW;
      ST_BAK:
        if (ret_req_q && ref_good_in)
          st_d = ST_SW;
      ST_SW:
        st_d = bak_target_q ? ST_BAK : ST_EXT;
      default:
        st_d = ST_EXT;
    endcase
  end

  // The PLL only starts when supplies are stable; no software needed.
  always @(posedge clk_in)
  begin
    if (!supply_good_in)
    begin
      st_q         <= ST_EXT;
      bak_target_q <= 1'b0;
      use_backup_q <= 1'b0;
      relock_q     <= 1'b1;
    end
    else if (ce_in)
    begin
      st_q <= st_d;
      if (st_q != ST_SW && st_d == ST_SW)
      begin
        bak_target_q <= (st_q == ST_EXT);
        relock_q     <= 1'b1;
      end
      else
        relock_q <= 1'b0;
      if (st_q == ST_SW)
        use_backup_q <= bak_target_q;
    end
  end

  // Lock time counter restarts on every source switch.
  always @(posedge clk_in)
  begin
    if (!supply_good_in)
    begin
      lock_cnt_q <= 16'h0000;
      locked_q   <= 1'b0;
    end
    else if (ce_in)
    begin
      if (relock_q || !lock_filt)
      begin
        lock_cnt_q <= 16'h0000;
        locked_q   <= 1'b0;
      end
      else if (lock_cnt_q >= LOCK_CYC[15:0] - FILT_CYC[15:0] - 16'h0001)
        locked_q <= 1'b1;
      else
        lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end

  assign use_backup_out = use_backup_q;
  assign pll_run_out    = supply_good_in;
  assign pll_div2_out   = sel_12m_q;
  assign pll_mult_out   = sel_12m_q ? MUL_LO : MUL_HI;
  assign mod_en_out     = mod_en_q;
  assign clk_lost_out   = !locked_q || (freq_bad && locked_q);
  assign irq_out        = clk_lost_out;
  assign drv_off_out    = clk_lost_out && drv_off_en_q;

  // Register read data, registered; unmapped addresses read zero.
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
      rdata_out <= 16'h0000;
    else if (ce_in)
    begin
      rdata_out <= 16'h0000;
      if (addr_in == `PBC_OFS_MOD_SETUP)
      begin
        rdata_out[`PBC_BIT_MOD_EN]  <= mod_en_q;
        rdata_out[`PBC_BIT_SEL_12M] <= sel_12m_q;
      end
      else if (addr_in == `PBC_OFS_FB_STATUS)
      begin
        rdata_out[`PBC_BIT_RET_EXT]    <= ret_req_q;
        rdata_out[`PBC_BIT_DRV_OFF_EN] <= drv_off_en_q;
        rdata_out[`PBC_BIT_ON_BACKUP]  <= use_backup_q;
        rdata_out[`PBC_BIT_CLK_LOST]   <= clk_lost_out;
        rdata_out[`PBC_BIT_LOCKED]     <= locked_q;
        rdata_out[`PBC_BIT_FREQ_BAD]   <= freq_bad;
      end
    end
  end
endmodule // pbc_clock_ctrl

// [verification/pbc_chk_props.sv]
// Concurrent checks on the fallback clock control ports.
`timescale 1ns/1ps
module pbc_chk (
  input wire        clk_in,
  input wire        ce_in,
  input wire        rst_n_in,
  input wire        supply_good_in,
  input wire        ref_good_in,
  input wire        pll_lock_raw_in,
  input wire        wr_en_in,
  input wire [8:0]  addr_in,
  input wire [15:0] wdata_in,
  input wire        use_backup_out,
  input wire        pll_run_out,
  input wire        pll_div2_out,
  input wire [4:0]  pll_mult_out,
  input wire        clk_lost_out,
  input wire        irq_out,
  input wire        drv_off_out
);
  wire cfg_wr = ce_in && wr_en_in && addr_in == 9'h1C6;
  wire ret_wr = ce_in && wr_en_in && addr_in == 9'h1C7 && wdata_in[0];
  reg  ret_seen_q;
  always @(posedge clk_in)
    ret_seen_q <= rst_n_in && (ret_wr || ret_seen_q && use_backup_out);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_irq_tracks_lost: assert property (
    irq_out == clk_lost_out) else $error("irq differs from loss");
  chk_drv_needs_loss: assert property (
    drv_off_out |-> clk_lost_out) else $error("drivers off, no loss");
  chk_mult_matches: assert property (
    pll_mult_out == (pll_div2_out ? 5'h0C : 5'h18)) else $error("mult");
  chk_run_on_supply: assert property (
    pll_run_out == supply_good_in) else $error("pll run wrong");
  chk_unlock_flagged: assert property (
    !pll_lock_raw_in && ce_in |-> ##[0:2] clk_lost_out)
    else $error("unlock not flagged");
  chk_bad_ref_backup: assert property (
    !ref_good_in && supply_good_in && ce_in |-> ##[0:2] use_backup_out)
    else $error("no fallback");
  chk_stay_backup: assert property (
    use_backup_out && supply_good_in && !ret_seen_q && !ret_wr
    |=> use_backup_out) else $error("left backup unasked");
  chk_sel_write: assert property (
    cfg_wr |=> pll_div2_out == $past(wdata_in[1])) else $error("select");
endmodule // pbc_chk
bind pbc_clock_ctrl pbc_chk chk (.clk_in, .ce_in, .rst_n_in,
  .supply_good_in, .ref_good_in, .pll_lock_raw_in, .wr_en_in, .addr_in,
  .wdata_in, .use_backup_out, .pll_run_out, .pll_div2_out, .pll_mult_out,
  .clk_lost_out, .irq_out, .drv_off_out);

// [verification/pbc_far_side.sv]
// Model of the reference source, backup tick and raw PLL lock.
`timescale 1ns/1ps
module pbc_far_side (
  input  wire       clk_in,
  input  wire [7:0] period_in,
  input  wire       ref_ok_in,
  input  wire       lock_ok_in,
  output reg        bk_tick_out,
  output wire       ref_good_out,
  output wire       lock_raw_out
);
  reg [7:0] cnt_q = 8'h00;
  initial bk_tick_out = 1'b0;
  // One backup clock edge per period of logic cycles.
  always @(posedge clk_in)
  begin
    cnt_q <= (cnt_q + 8'h01 >= period_in) ? 8'h00 : cnt_q + 8'h01;
    bk_tick_out <= (cnt_q == 8'h00);
  end
  assign ref_good_out = ref_ok_in;
  assign lock_raw_out = lock_ok_in;
endmodule // pbc_far_side

// [verification/pbc_clock_ctrl_tb.sv]
// Self-checking bench for the fallback clock control block.
`timescale 1ns/1ps
module pbc_clock_ctrl_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         sup = 1'b0;
  reg         ext = 1'b1;
  reg         wr = 1'b0;
  reg  [8:0]  addr = 9'h000;
  reg  [15:0] wd = 16'h0000;
  reg  [7:0]  per = 8'h12;
  reg         ref_ok = 1'b1;
  reg         lk = 1'b1;
  wire [15:0] rd;
  wire [4:0]  mult;
  wire        tick, refg, lraw, bk, run, div2, mod, lost, irq, drv;
  integer     miscompares = 0;
  integer     checks = 0;
  always #12.5 clk = ~clk;
  pbc_far_side fs (.clk_in(clk), .period_in(per), .ref_ok_in(ref_ok),
    .lock_ok_in(lk), .bk_tick_out(tick), .ref_good_out(refg),
    .lock_raw_out(lraw));
  pbc_clock_ctrl #(.LOCK_CYC(20), .FILT_CYC(8)) uut (.clk_in(clk),
    .ce_in(1'b1), .rst_n_in(rst_n), .supply_good_in(sup),
    .external_reset_pin_in(ext), .ref_good_in(refg), .bk_tick_in(tick),
    .pll_lock_raw_in(lraw), .wr_en_in(wr), .addr_in(addr),
    .wdata_in(wd), .rdata_out(rd), .use_backup_out(bk),
    .pll_run_out(run), .pll_div2_out(div2), .pll_mult_out(mult),
    .mod_en_out(mod), .clk_lost_out(lost), .irq_out(irq),
    .drv_off_out(drv));
  task tally_and_finish;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [15:0] ex, input [15:0] got);
  begin
    checks = checks + 1;
    if (got !== ex)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0s exp %h got %h", nm, ex, got);
    end
  end
  endtask
  task step(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task wrt(input [8:0] a, input [15:0] d);
  begin
    wr = 1'b1;
    addr = a;
    wd = d;
    step(1);
    wr = 1'b0;
  end
  endtask
  task rdc(input [8:0] a, input [15:0] ex);
  begin
    addr = a;
    step(1);
    chk("rdata", ex, rd);
  end
  endtask
  task await(input sel, input v, input integer n);
  begin
    while (((sel ? bk : lost) !== v) && n > 0)
    begin
      step(1);
      n = n - 1;
    end
    chk(sel ? "backup" : "lost", v, sel ? bk : lost);
    if ((sel ? bk : lost) !== v)
      tally_and_finish;
  end
  endtask
  task t_reset;
  begin
    rdc(9'h1C6, 16'h0001);
    rdc(9'h1FF, 16'h0000);
    chk("mult", 5'h18, mult);
    chk("lost", 1'b1, lost);
  end
  endtask
  task t_lock;
  begin
    sup = 1'b1;
    await(0, 0, 800);
    chk("irq", 1'b0, irq);
  end
  endtask
  task t_sel;
  begin
    wrt(9'h1C6, 16'h0002);
    chk("mult", 5'h0C, mult);
    chk("div2", 1'b1, div2);
    chk("mod", 1'b0, mod);
    per = 8'h09;
    wrt(9'h1C6, 16'h0001);
    await(0, 1, 800);
    per = 8'h12;
    await(0, 0, 800);
  end
  endtask
  task t_fall;
  begin
    ref_ok = 1'b0;
    await(1, 1, 5);
    await(0, 1, 5);
    ref_ok = 1'b1;
    step(100);
    chk("backup", 1'b1, bk);
    await(0, 0, 800);
    wrt(9'h1C7, 16'h0001);
    await(1, 0, 5);
    await(0, 0, 800);
  end
  endtask
  task t_drv;
  begin
    wrt(9'h1C7, 16'h0002);
    lk = 1'b0;
    ext = 1'b0;
    await(0, 1, 5);
    chk("drv", 1'b1, drv);
    chk("run", 1'b1, run);
    lk = 1'b1;
    ext = 1'b1;
    await(0, 0, 800);
    chk("drv", 1'b0, drv);
  end
  endtask
  initial
  begin
    step(6);
    rst_n = 1'b1;
    t_reset;
    t_lock;
    t_sel;
    t_fall;
    t_drv;
    tally_and_finish;
  end
endmodule // pbc_clock_ctrl_tb
